// ### dsacc_pkg.sv
// package: constants and types of the dual converter control block
`default_nettype none
package dsacc_pkg;
  localparam int unsigned CFG_W = 12;
  localparam logic [11:0] CFG_RESET = 12'h000;
  localparam int unsigned CH_HI = 11;
  localparam int unsigned CH_LO = 10;
  localparam int unsigned UPD_HI = 9;
  localparam int unsigned UPD_LO = 8;
  localparam int unsigned DEEP_BIT = 7;
  localparam int unsigned NAP_BIT = 6;
  localparam int unsigned AUTO_NAP_BIT = 5;
  localparam int unsigned REF_OFF_BIT = 4;
  localparam int unsigned CMD_HI = 2;
  localparam int unsigned CMD_LO = 0;
  localparam logic [1:0] UPD_ENABLED = 2'h1;
  localparam logic [2:0] CMD_DAC_WRITE = 3'h1;
  localparam logic [2:0] CMD_DAC_READ = 3'h3;
  localparam logic [2:0] CMD_SEQ_WRITE = 3'h4;
  localparam logic [2:0] CMD_SW_RESET = 3'h5;
  localparam logic [2:0] CMD_SEQ_READ = 3'h6;
  localparam int unsigned DAC_W = 10;
  localparam logic [9:0] DAC_RESET = 10'h3ff;
  localparam logic [11:0] SEQ_RESET = 12'h000;
  localparam int unsigned CONV_CYCLES = 12;
  localparam int unsigned PRECHARGE_CYCLES = 1;
  localparam int unsigned MIN_SAMPLE_CYCLES = 2;
  localparam int unsigned TOTAL_MIN_CYCLES = 16;
  localparam int unsigned CLK_PERIOD_PS = 10000;
  localparam int unsigned TRIG_SETUP_PS = 10000;
  localparam int unsigned TRIG_SETUP_CYCLES =
    (TRIG_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned ACQ_TYP_PS = 62500;
  localparam int unsigned ACQ_TYP_CYCLES =
    (ACQ_TYP_PS / CLK_PERIOD_PS) < 1 ? 1 : ACQ_TYP_PS / CLK_PERIOD_PS;

  typedef enum logic [2:0] {
    DSACC_ACQ = 3'b001,
    DSACC_CONV = 3'b010,
    DSACC_PRECHG = 3'b100
  } dsacc_phase_e;

  typedef enum logic [1:0] {
    DSACC_NEXT_NONE = 2'h0,
    DSACC_NEXT_DAC = 2'h1,
    DSACC_NEXT_SEQ = 2'h2
  } dsacc_pend_e;

  typedef struct packed {
    logic [1:0] channel;
    logic [1:0] update_enable_bits;
    logic deep_sleep_bit;
    logic nap_bit;
    logic auto_nap_bit;
    logic reference_off_bit;
    logic unused_bit;
    logic [2:0] command_select_bits;
  } dsacc_cfg_s;

  typedef struct packed {
    logic deep;
    logic nap;
    logic auto_nap;
    logic ref_off;
  } dsacc_power_s;

  typedef struct packed {
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
  } dsacc_mux_s;

  // mux code -> one-hot of pair0_pos, pair0_neg, pair1_pos, pair1_neg
  function automatic dsacc_mux_s dsacc_mux_decode(input logic [1:0] ch);
    dsacc_mux_s m;
    m = '0;
    case (ch)
      2'h0: begin
        m.pos_sel = 4'h1;
        m.neg_sel = 4'h2;
      end
      2'h1: begin
        m.pos_sel = 4'h8;
        m.neg_sel = 4'h2;
      end
      2'h2: begin
        m.pos_sel = 4'h4;
        m.neg_sel = 4'h2;
      end
      default: begin
        m.pos_sel = 4'h4;
        m.neg_sel = 4'h8;
      end
    endcase
    return m;
  endfunction
endpackage
`default_nettype wire

// ### dsacc_conv_seq.sv
// conversion timing: acquisition, conversion and pre-charge phases
`default_nettype none
module dsacc_conv_seq
  import dsacc_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic trig_fall,
  output logic busy,
  output logic hold,
  output logic precharge,
  output logic result_strobe
);
  // the phase counter is eight bits wide
  if (CONV_LEN < 1 || CONV_LEN > 255) begin : g_len_check
    $error("conversion length out of range");
  end

  dsacc_phase_e phase;
  logic [7:0] cnt;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= DSACC_ACQ;
      cnt <= 8'h00;
    end else begin
      case (phase)
        DSACC_ACQ: begin
          if (trig_fall) begin
            phase <= DSACC_CONV;
            cnt <= 8'h00;
          end
        end
        DSACC_CONV: begin
          if (cnt == 8'(CONV_LEN - 1)) begin
            phase <= DSACC_PRECHG;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        DSACC_PRECHG: begin
          phase <= DSACC_ACQ;
        end
        default: begin
          phase <= DSACC_ACQ;
        end
      endcase
    end
  end

  assign busy = (phase == DSACC_CONV);
  assign hold = (phase != DSACC_ACQ);
  assign precharge = (phase == DSACC_PRECHG);
  assign result_strobe = (phase == DSACC_CONV) &&
    (cnt == 8'(CONV_LEN - 1));
endmodule // dsacc_conv_seq
`default_nettype wire

// ### dsacc_top.sv
// dual converter control: configuration register and conversion control
`default_nettype none
module dsacc_top
  import dsacc_pkg::*;
#(
  parameter int unsigned RES_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic conversion_trigger,
  input wire logic write_strobe,
  input wire logic [11:0] parallel_data_bus,
  input wire logic [RES_W-1:0] result_a_raw,
  input wire logic [RES_W-1:0] result_b_raw,
  output logic busy,
  output logic sample_hold,
  output logic precharge,
  output dsacc_mux_s mux_route,
  output dsacc_power_s power_mode,
  output logic [DAC_W-1:0] reference_dac_code,
  output logic [11:0] sequencer_setting,
  output logic dac_read_pending,
  output logic seq_read_pending,
  output logic [RES_W-1:0] result_a,
  output logic [RES_W-1:0] result_b
);
  if (RES_W != 12) begin : g_res_check
    $error("result width must be 12");
  end

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [1:0] trig_sync;
  logic trig_last;
  logic [1:0] wr_sync;
  logic wr_last;
  logic [11:0] bus_s1;
  logic [11:0] bus_s2;
  logic [11:0] bus_hold;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trig_sync <= 2'h3;
      trig_last <= 1'b1;
      wr_sync <= 2'h0;
      wr_last <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], conversion_trigger};
      trig_last <= trig_sync[1];
      wr_sync <= {wr_sync[0], write_strobe};
      wr_last <= wr_sync[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      bus_s1 <= 12'h000;
      bus_s2 <= 12'h000;
      bus_hold <= 12'h000;
    end else begin
      bus_s1 <= parallel_data_bus;
      bus_s2 <= bus_s1;
      bus_hold <= bus_s2;
    end
  end

  logic trig_fall;
  logic wr_rise;
  assign trig_fall = trig_last && !trig_sync[1];
  // data held steady around the strobe; bus_hold has one more stage than wr_sync, so the sample is taken one cycle before its edge
  assign wr_rise = wr_sync[1] && !wr_last;

  ////////////////////////////////////////////////////////////////////////
  // configuration register and two-access commands
  dsacc_cfg_s cfg;
  dsacc_cfg_s incoming;
  dsacc_pend_e pending;
  logic cfg_write;
  logic sw_reset;

  assign incoming = dsacc_cfg_s'(bus_hold);
  // second access of a reference or sequencer write carries data only
  assign cfg_write = wr_rise && (pending == DSACC_NEXT_NONE);
  assign sw_reset = cfg_write &&
    incoming.update_enable_bits == UPD_ENABLED &&
    incoming.command_select_bits == CMD_SW_RESET;

  always_ff @(posedge core_clk) begin
    if (!resetn || sw_reset) begin
      cfg <= dsacc_cfg_s'(CFG_RESET);
    end else if (cfg_write) begin
      cfg <= incoming;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || sw_reset) begin
      pending <= DSACC_NEXT_NONE;
    end else if (wr_rise) begin
      if (pending != DSACC_NEXT_NONE) begin
        pending <= DSACC_NEXT_NONE;
      end else if (incoming.update_enable_bits == UPD_ENABLED) begin
        case (incoming.command_select_bits)
          CMD_DAC_WRITE: pending <= DSACC_NEXT_DAC;
          CMD_SEQ_WRITE: pending <= DSACC_NEXT_SEQ;
          default: pending <= DSACC_NEXT_NONE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || sw_reset) begin
      reference_dac_code <= DAC_RESET;
      sequencer_setting <= SEQ_RESET;
    end else if (wr_rise) begin
      if (pending == DSACC_NEXT_DAC) begin
        reference_dac_code <= bus_hold[DAC_W-1:0];
      end
      if (pending == DSACC_NEXT_SEQ) begin
        sequencer_setting <= bus_hold;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || sw_reset) begin
      dac_read_pending <= 1'b0;
      seq_read_pending <= 1'b0;
    end else if (cfg_write) begin
      dac_read_pending <= incoming.update_enable_bits == UPD_ENABLED &&
        incoming.command_select_bits == CMD_DAC_READ;
      seq_read_pending <= incoming.update_enable_bits == UPD_ENABLED &&
        incoming.command_select_bits == CMD_SEQ_READ;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power and multiplexer outputs
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      power_mode <= '0;
      mux_route <= dsacc_mux_decode(2'h0);
    end else begin
      power_mode.deep <= cfg.deep_sleep_bit;
      power_mode.nap <= cfg.nap_bit;
      power_mode.auto_nap <= cfg.auto_nap_bit;
      power_mode.ref_off <= cfg.reference_off_bit;
      mux_route <= dsacc_mux_decode(cfg.channel);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sequencing and result capture
  logic result_strobe;

  dsacc_conv_seq #(
    .CONV_LEN(CONV_CYCLES)
  ) u_conv (
    .core_clk(core_clk),
    .resetn(resetn),
    .trig_fall(trig_fall),
    .busy(busy),
    .hold(sample_hold),
    .precharge(precharge),
    .result_strobe(result_strobe)
  );

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      result_a <= '0;
      result_b <= '0;
    end else if (result_strobe) begin
      result_a <= result_a_raw;
      result_b <= result_b_raw;
    end
  end
endmodule // dsacc_top
`default_nettype wire

// ### dsacc_monitor.sv
// checker: timing and register relations at the converter control ports
`default_nettype none
module dsacc_monitor
  import dsacc_pkg::*;
#(
  parameter int unsigned RES_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic conversion_trigger,
  input wire logic write_strobe,
  input wire logic [11:0] parallel_data_bus,
  input wire logic [RES_W-1:0] result_a_raw,
  input wire logic [RES_W-1:0] result_b_raw,
  input wire logic busy,
  input wire logic sample_hold,
  input wire logic precharge,
  input wire dsacc_mux_s mux_route,
  input wire dsacc_power_s power_mode,
  input wire logic [DAC_W-1:0] reference_dac_code,
  input wire logic [11:0] sequencer_setting,
  input wire logic dac_read_pending,
  input wire logic seq_read_pending,
  input wire logic [RES_W-1:0] result_a,
  input wire logic [RES_W-1:0] result_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  busy_length_a: assert property ($rose(busy) |-> busy[*8] ##1 busy[*4]
    ##1 (!busy && precharge)) else $error("busy length wrong");
  precharge_once_a: assert property (precharge |=>
    !precharge && !busy && !sample_hold) else $error("precharge too long");
  hold_span_a: assert property (sample_hold == (busy || precharge))
    else $error("hold not matching phases");
  conv_start_a: assert property ($fell(conversion_trigger) && !sample_hold
    |-> ##[2:4] $rose(busy)) else $error("conversion did not start");
  busy_cause_a: assert property ($rose(busy) |->
    !$past(conversion_trigger)) else $error("busy without trigger");
  result_load_a: assert property ($fell(busy) |->
    result_a == $past(result_a_raw) && result_b == $past(result_b_raw))
    else $error("result not captured");
  result_keep_a: assert property (!busy |=>
    $stable(result_a) && $stable(result_b)) else $error("result moved");
  mux_legal_a: assert property (mux_route inside
    {8'h12, 8'h82, 8'h42, 8'h48}) else $error("illegal mux route");
  cfg_after_wr_a: assert property ($changed(mux_route) ||
    $changed(power_mode) |-> $past(write_strobe, 4)) else $error("cfg moved");
  dac_after_wr_a: assert property ($changed(reference_dac_code) ||
    $changed(sequencer_setting) |-> $past(write_strobe, 3))
    else $error("dac or sequencer moved");
endmodule // dsacc_monitor
bind dsacc_top dsacc_monitor #(.RES_W(RES_W)) i_dsacc_monitor (
  .core_clk(core_clk), .resetn(resetn),
  .conversion_trigger(conversion_trigger), .write_strobe(write_strobe),
  .parallel_data_bus(parallel_data_bus), .result_a_raw(result_a_raw),
  .result_b_raw(result_b_raw), .busy(busy), .sample_hold(sample_hold),
  .precharge(precharge), .mux_route(mux_route), .power_mode(power_mode),
  .reference_dac_code(reference_dac_code),
  .sequencer_setting(sequencer_setting),
  .dac_read_pending(dac_read_pending), .seq_read_pending(seq_read_pending),
  .result_a(result_a), .result_b(result_b));
`default_nettype wire

// ### dsacc_core_model.sv
// partner: converter core stand-in giving result words every cycle
`default_nettype none
module dsacc_core_model #(
  parameter int unsigned RES_W = 12
) (
  input wire logic core_clk,
  input wire logic resetn,
  output logic [RES_W-1:0] result_a_raw,
  output logic [RES_W-1:0] result_b_raw
);
  // words move every cycle so an early or late capture shows
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      result_a_raw <= RES_W'(12'h7ff);
    end else begin
      result_a_raw <= result_a_raw + RES_W'(12'h2b5);
    end
  end
  assign result_b_raw = ~result_a_raw;
endmodule // dsacc_core_model
`default_nettype wire

// ### test_dsacc_top.sv
// testbench: configuration writes and conversion timing
`default_nettype none
module test_dsacc_top import dsacc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic conversion_trigger = 1'b1;
  logic write_strobe = 1'b0;
  logic [11:0] parallel_data_bus = 12'h000;
  logic [11:0] result_a_raw, result_b_raw, result_a, result_b;
  logic busy, sample_hold, precharge, dac_read_pending, seq_read_pending;
  dsacc_mux_s mux_route;
  dsacc_power_s power_mode;
  logic [9:0] reference_dac_code, v;
  logic [11:0] sequencer_setting, w;
  int fails = 0;
  int total_checks = 0;
  int seed = 45;
  int n;
  dsacc_core_model i_dsacc_core_model (.core_clk(core_clk), .resetn(resetn),
    .result_a_raw(result_a_raw), .result_b_raw(result_b_raw));
  dsacc_top i_dsacc_top (.core_clk(core_clk), .resetn(resetn),
    .conversion_trigger(conversion_trigger), .write_strobe(write_strobe),
    .parallel_data_bus(parallel_data_bus), .result_a_raw(result_a_raw),
    .result_b_raw(result_b_raw), .busy(busy), .sample_hold(sample_hold),
    .precharge(precharge), .mux_route(mux_route), .power_mode(power_mode),
    .reference_dac_code(reference_dac_code),
    .sequencer_setting(sequencer_setting),
    .dac_read_pending(dac_read_pending), .seq_read_pending(seq_read_pending),
    .result_a(result_a), .result_b(result_b));
  function automatic logic [11:0] mux_exp(input logic [1:0] ch);
    case (ch)
      2'h0: return 12'h012;
      2'h1: return 12'h082;
      2'h2: return 12'h042;
      default: return 12'h048;
    endcase
  endfunction
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [11:0] d);
    @(negedge core_clk);
    parallel_data_bus = d;
    repeat (4) @(negedge core_clk);
    write_strobe = 1'b1;
    repeat (6) @(negedge core_clk);
    write_strobe = 1'b0;
    parallel_data_bus = ~d;
    repeat (3) @(negedge core_clk);
  endtask
  // again: a second fall while busy, which must be ignored
  task automatic conv(input bit again);
    @(negedge core_clk);
    conversion_trigger = 1'b0;
    n = 0;
    while (busy !== 1'b1) begin
      n++;
      if (n > 8) begin
        fails++;
        summarize();
      end
      @(negedge core_clk);
    end
    n = 0;
    while (busy === 1'b1 && n < 20) begin
      n++;
      if (n == 4) conversion_trigger = 1'b1;
      if (n == 7 && again) conversion_trigger = 1'b0;
      w = result_a_raw;
      @(negedge core_clk);
    end
    chk(12'(n), 12'h00c);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    chk(precharge, 1'b1);
    chk(sample_hold, 1'b1);
    chk(result_a, w);
    chk(result_b, ~result_a);
    conversion_trigger = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(busy, 1'b0);
  endtask
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (3) @(negedge core_clk);
    resetn = 1'b1;
    repeat (4) @(negedge core_clk);
    chk(mux_route, 12'h012);
    chk(power_mode, 12'h0);
    chk(reference_dac_code, 12'h3ff);
    chk(sequencer_setting, 12'h000);
    for (int c = 0; c < 4; c++) begin
      w = 12'($random(seed));
      w[11:10] = c[1:0];
      w[9:8] = w[9] ? 2'h3 : 2'h0;
      wr(w);
      chk(mux_route, mux_exp(c[1:0]));
      chk(power_mode, w[7:4]);
    end
    wr(12'h800);
    chk(power_mode, 12'h0);
    conv(1'b0);
    conv(1'b1);
    wr({2'h3, 2'h1, 5'h00, CMD_DAC_WRITE});
    v = 10'(($random(seed) & 32'h1ff) + 205);
    wr({2'h0, v});
    chk(reference_dac_code, v);
    chk(mux_route, 12'h048);
    wr({2'h0, 2'h3, 5'h00, CMD_DAC_WRITE});
    wr(12'h0cd);
    chk(reference_dac_code, v);
    chk(power_mode, 12'hc);
    wr({2'h0, 2'h1, 5'h00, CMD_SEQ_WRITE});
    w = 12'($random(seed));
    wr(w);
    chk(sequencer_setting, w);
    wr({2'h0, 2'h1, 5'h00, CMD_DAC_READ});
    chk(dac_read_pending, 1'b1);
    wr({2'h0, 2'h1, 5'h00, CMD_SEQ_READ});
    chk(seq_read_pending, 1'b1);
    wr({2'h2, 2'h1, 5'h00, CMD_SW_RESET});
    chk(reference_dac_code, 12'h3ff);
    chk(sequencer_setting, 12'h000);
    chk(mux_route, 12'h012);
    for (int k = 0; k < 3; k++) begin
      wr({2'(k + 1), 2'h1, 5'h00, (k == 0) ? 3'h0 : (k == 1) ? 3'h2 : 3'h7});
      chk(mux_route, mux_exp(2'(k + 1)));
      chk(reference_dac_code, 12'h3ff);
    end
    summarize();
  end
endmodule // test_dsacc_top
`default_nettype wire
